// file: lmfe_defines.vh
// constants for the led matrix serial frame engine
// assumes 32-bit frames, msb first, sampled on rising serial clock
// Behaviour
// - call type 01 addresses one device, 10 all or cluster; 00 and 11 invalid
// - addressed device drives log or read answer for 24 bits after edge 8; others release
// - frame bits 22:16 hold a 7-bit register address, 128 locations
// - write frame bits 15:3 carry the 13-bit register value or operation
// - input checksum over bits 31:3, poly 0x5, seed 000, in last three bits
// - frame accepted only when computed input checksum matches received one
// - write frame output low from select fall, eight zeros, then 24-bit log
// - clocks beyond 32 bits give zero output and set clock-count error
// - write qualifies only if 32 bits, checksum good, writable address
// - qualified write executes, updates register, logs success
// - failed write not executed; sticky error and diagnostic set, logged
// - read frame has msb one and all-zero 13-bit data field
// - read output: eight zeros, error flag, 7 status, 13 data, checksum
// - output checksum over output bits 23:3, poly 0x5, seed 000
// - read qualifies only if 32 bits, checksum good, zero data, call 01
// - qualified read applies clear-on-read and logs requested content
// - failed read leaves clear-on-read alone, sets flags, logs failure
// - read response is driven whether or not the read qualifies
// - all-device call is write only; such reads are errors
// - frame bit 31 zero marks a write
// - input sampled on rising serial clock; master changes on falling
`ifndef LMFE_DEFINES_VH
`define LMFE_DEFINES_VH
`define LMFE_FRAME_BITS 6'd32
`define LMFE_HDR_BITS 6'd8
`define LMFE_CNT_MAX 6'h3f
`define LMFE_RW_BIT 31
`define LMFE_CMD_HI 30
`define LMFE_CMD_LO 29
`define LMFE_ID_HI 28
`define LMFE_ID_LO 24
`define LMFE_ADDR_HI 22
`define LMFE_ADDR_LO 16
`define LMFE_DATA_HI 15
`define LMFE_DATA_LO 3
`define LMFE_CRC_HI 2
`define LMFE_CALL_INDIV 2'h1
`define LMFE_CALL_GROUP 2'h2
`define LMFE_CRC_POLY 3'h5
`define LMFE_CRC_INIT 3'h0
`define LMFE_IN_CRC_LEN 6'd29
`define LMFE_OUT_CRC_LEN 6'd21
`endif

// file: lmfe_fe_monitor.sv
// port checker for the frame engine
// assumes one clk domain with rst active high
`timescale 1ns/10ps
module lmfe_fe_monitor (
    // clock and reset
    input wire clk,
    input wire rst,
    // link and register side
    input wire chipSelectN,
    input wire sdo,
    input wire sdoOe,
    input wire [6:0] regAddr,
    input wire [12:0] regWrData,
    input wire regWrStb,
    input wire regRdClrStb,
    input wire [12:0] regRdData,
    // flags and log
    input wire errClear,
    input wire ifErr,
    input wire crcErr,
    input wire wrErr,
    input wire [23:0] transactionLog
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // deselect held past the synchroniser depth
    sequence sIdle;
        chipSelectN [*5];
    endsequence
    sequence sSel;
        $fell(chipSelectN);
    endsequence
    sequence sFail;
        $rose(crcErr) || $rose(wrErr);
    endsequence
    a_idle_release: assert property (sIdle |-> !sdoOe)
        else $error("sdo driven while deselected");
    a_select_low: assert property (sSel |-> ##[1:4] (sdoOe && !sdo))
        else $error("no low drive after select");
    a_strobe_pulse: assert property (regWrStb |=> !regWrStb)
        else $error("write strobe longer than one cycle");
    a_write_log: assert property (regWrStb |-> transactionLog == {4'h8, regAddr, regWrData})
        else $error("write log mismatch");
    a_read_log: assert property (regRdClrStb |-> transactionLog[23]
        && transactionLog[12:0] == $past(regRdData))
        else $error("read log mismatch");
    a_err_sticky: assert property (ifErr && !errClear |=> ifErr)
        else $error("error flag lost");
    a_fail_flag: assert property (sFail |-> ifErr)
        else $error("diagnostic without error flag");
    a_fail_noexec: assert property (sFail |-> !regWrStb && !regRdClrStb)
        else $error("failed frame executed");
endmodule

// file: lmfe_frame_engine.v
// slave frame engine: decodes 32-bit frames, qualifies, logs, answers
// assumes serial pins are asynchronous to clk and much slower than it
`timescale 1ns/10ps
`include "lmfe_defines.vh"
module lmfe_frame_engine (
    // clock and reset
    input wire clk,
    input wire rst,
    // serial link pins
    input wire sclk,
    input wire chipSelectN,
    input wire sdi,
    output wire sdo,
    output wire sdoOe,
    // identity strap and status
    input wire [4:0] ownIdStrap,
    input wire [6:0] generalStatusBits,
    // register side
    output wire [6:0] regAddr,
    output wire [12:0] regWrData,
    output wire regWrStb,
    output wire regRdClrStb,
    input wire wrAddrOk,
    input wire rdAddrOk,
    input wire [12:0] regRdData,
    // error flags and log
    input wire errClear,
    output wire ifErr,
    output wire clkErr,
    output wire crcErr,
    output wire wrErr,
    output wire rdErr,
    output wire [23:0] transactionLog
);
    // input checksum over frame, output checksum over response payload
    function [2:0] crc3;
        input [31:0] msg;
        input [5:0] len;
        integer i;
        reg [2:0] c;
        reg fb;
        begin
            c = `LMFE_CRC_INIT;
            for (i = 0; i < 32; i = i + 1) begin
                if (i < len) begin
                    fb = msg[31 - i] ^ c[2];
                    c = {c[1:0], 1'b0} ^ (fb ? `LMFE_CRC_POLY : 3'h0);
                end
            end
            crc3 = c;
        end
    endfunction

    reg sclkS1_r, sclkS2_r, sclkS3_r;
    reg csS1_r, csS2_r, csS3_r;
    reg sdiS1_r, sdiS2_r;
    reg [31:0] inShift_r;
    reg [5:0] bitCnt_r;
    reg active_r;
    reg selected_r;
    reg [23:0] outShift_r;
    reg sdo_r, sdoOe_r;
    reg [4:0] ownId_r;
    reg [4:0] idSync_r;
    reg idArm_r;
    reg idTaken_r;
    reg evalPend_r;
    reg [31:0] frame_r;
    reg frameLenOk_r;
    reg [6:0] regAddr_r;
    reg [12:0] regWrData_r;
    reg regWrStb_r, regRdClrStb_r;
    reg ifErr_r, clkErr_r, crcErr_r, wrErr_r, rdErr_r;
    reg [23:0] log_r;

    wire sclkRise = sclkS2_r & ~sclkS3_r;
    wire sclkFall = ~sclkS2_r & sclkS3_r;
    wire csFall = ~csS2_r & csS3_r;
    wire csRise = csS2_r & ~csS3_r;
    wire [31:0] inNxt = {inShift_r[30:0], sdiS2_r};
    wire [1:0] hdrCmd = inNxt[`LMFE_CMD_HI - `LMFE_ID_LO:`LMFE_CMD_LO - `LMFE_ID_LO];
    wire [4:0] hdrId = inNxt[`LMFE_ID_HI - `LMFE_ID_LO:0];
    wire hdrRead = inNxt[`LMFE_RW_BIT - `LMFE_ID_LO];
    wire hdrIdMatch = (hdrId == ownId_r);
    // individual call only for own id; group call reaches every device
    wire hdrSel = (hdrCmd == `LMFE_CALL_GROUP) ? 1'b1 : hdrIdMatch;
    // read answer: error flag, status, data field of the last log, checksum
    wire [20:0] rdPayload = {ifErr_r, generalStatusBits, log_r[12:0]};
    wire [2:0] outCrc = crc3({rdPayload, 11'h0}, `LMFE_OUT_CRC_LEN);

    // two-flop synchronisers, a third stage only for edge finding
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclkS1_r <= 1'b0;
            sclkS2_r <= 1'b0;
            sclkS3_r <= 1'b0;
            csS1_r <= 1'b1;
            csS2_r <= 1'b1;
            csS3_r <= 1'b1;
            sdiS1_r <= 1'b0;
            sdiS2_r <= 1'b0;
        end else begin
            sclkS1_r <= sclk;
            sclkS2_r <= sclkS1_r;
            sclkS3_r <= sclkS2_r;
            csS1_r <= chipSelectN;
            csS2_r <= csS1_r;
            csS3_r <= csS2_r;
            sdiS1_r <= sdi;
            sdiS2_r <= sdiS1_r;
        end
    end

    // strap passes two flops, then is frozen once after reset release
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            idSync_r <= 5'h0;
            idArm_r <= 1'b0;
            ownId_r <= 5'h0;
            idTaken_r <= 1'b0;
        end else begin
            idSync_r <= ownIdStrap;
            if (!idTaken_r) begin
                ownId_r <= idSync_r;
                idTaken_r <= idArm_r;
                idArm_r <= 1'b1;
            end
        end
    end

    // shifting in, bit counting, header decode and output drive
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            inShift_r <= 32'h0;
            bitCnt_r <= 6'h0;
            active_r <= 1'b0;
            selected_r <= 1'b0;
            outShift_r <= 24'h0;
            sdo_r <= 1'b0;
            sdoOe_r <= 1'b0;
        end else if (csFall) begin
            // drive low at once, first eight bits are zeros
            inShift_r <= 32'h0;
            bitCnt_r <= 6'h0;
            active_r <= 1'b1;
            selected_r <= 1'b0;
            outShift_r <= 24'h0;
            sdo_r <= 1'b0;
            sdoOe_r <= 1'b1;
        end else if (csRise || csS2_r) begin
            active_r <= 1'b0;
            sdo_r <= 1'b0;
            sdoOe_r <= 1'b0;
        end else if (active_r) begin
            if (sclkRise) begin
                inShift_r <= inNxt;
                if (bitCnt_r != `LMFE_CNT_MAX)
                    bitCnt_r <= bitCnt_r + 6'd1;
                if (bitCnt_r == `LMFE_HDR_BITS - 6'd1) begin
                    selected_r <= hdrSel;
                    sdoOe_r <= hdrSel;
                    // read answer goes out even if it later fails
                    if (hdrRead)
                        outShift_r <= {rdPayload, outCrc};
                    else
                        outShift_r <= log_r;
                end
            end else if (sclkFall && bitCnt_r >= `LMFE_HDR_BITS) begin
                // zeros refill behind, so extra clocks read back as zero
                sdo_r <= outShift_r[23];
                outShift_r <= {outShift_r[22:0], 1'b0};
            end
        end
    end

    // end of frame: latch the frame, evaluate one cycle later
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            evalPend_r <= 1'b0;
            frame_r <= 32'h0;
            frameLenOk_r <= 1'b0;
            regAddr_r <= 7'h0;
            regWrData_r <= 13'h0;
        end else begin
            evalPend_r <= csRise & active_r & selected_r;
            if (csRise && active_r) begin
                frame_r <= inShift_r;
                frameLenOk_r <= (bitCnt_r == `LMFE_FRAME_BITS);
                regAddr_r <= inShift_r[`LMFE_ADDR_HI:`LMFE_ADDR_LO];
                regWrData_r <= inShift_r[`LMFE_DATA_HI:`LMFE_DATA_LO];
            end
        end
    end

    wire evRead = frame_r[`LMFE_RW_BIT];
    wire [1:0] evCmd = frame_r[`LMFE_CMD_HI:`LMFE_CMD_LO];
    wire evCrcOk = (crc3(frame_r, `LMFE_IN_CRC_LEN) ==
                    frame_r[`LMFE_CRC_HI:0]);
    wire evCmdValid = (evCmd == `LMFE_CALL_INDIV) || (evCmd == `LMFE_CALL_GROUP);
    wire evWrBad = !wrAddrOk || !evCmdValid;
    // group reads and non-zero data fields make a read fail
    wire evRdBad = (evCmd != `LMFE_CALL_INDIV) || !rdAddrOk
                   || (regWrData_r != 13'h0);
    wire evCmdBad = evRead ? evRdBad : evWrBad;
    wire evOk = frameLenOk_r && evCrcOk && !evCmdBad;

    // execute, log, and keep sticky flags; a new error wins over clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            regWrStb_r <= 1'b0;
            regRdClrStb_r <= 1'b0;
            log_r <= 24'h0;
            ifErr_r <= 1'b0;
            clkErr_r <= 1'b0;
            crcErr_r <= 1'b0;
            wrErr_r <= 1'b0;
            rdErr_r <= 1'b0;
        end else begin
            regWrStb_r <= evalPend_r & evOk & !evRead;
            regRdClrStb_r <= evalPend_r & evOk & evRead;
            if (evalPend_r) begin
                // log: ok, len, crc, command errors, address, data
                log_r <= {evOk, !frameLenOk_r, !evCrcOk, evCmdBad, regAddr_r,
                          (evRead && evOk) ? regRdData : regWrData_r};
            end
            if (evalPend_r && !evOk)
                ifErr_r <= 1'b1;
            else if (errClear)
                ifErr_r <= 1'b0;
            if (evalPend_r && !frameLenOk_r)
                clkErr_r <= 1'b1;
            else if (errClear)
                clkErr_r <= 1'b0;
            if (evalPend_r && !evCrcOk)
                crcErr_r <= 1'b1;
            else if (errClear)
                crcErr_r <= 1'b0;
            if (evalPend_r && !evRead && evWrBad)
                wrErr_r <= 1'b1;
            else if (errClear)
                wrErr_r <= 1'b0;
            if (evalPend_r && evRead && evRdBad)
                rdErr_r <= 1'b1;
            else if (errClear)
                rdErr_r <= 1'b0;
        end
    end

    assign sdo = sdo_r;
    assign sdoOe = sdoOe_r;
    assign regAddr = regAddr_r;
    assign regWrData = regWrData_r;
    assign regWrStb = regWrStb_r;
    assign regRdClrStb = regRdClrStb_r;
    assign ifErr = ifErr_r;
    assign clkErr = clkErr_r;
    assign crcErr = crcErr_r;
    assign wrErr = wrErr_r;
    assign rdErr = rdErr_r;
    assign transactionLog = log_r;
endmodule

// file: lmfe_spi_master.sv
// serial master model: sends one frame, keeps the last 32 answer bits
// assumes sclk idles low; a released sdo reads as the inverted last bit
`timescale 1ns/10ps
module lmfe_spi_master (
    // link pins
    output reg sclk,
    output reg chipSelectN,
    output reg sdi,
    input wire sdo,
    input wire sdoOe
);
    initial begin
        sclk = 1'b0;
        chipSelectN = 1'b1;
        sdi = 1'b0; // pulled-down idle level
    end
    // n rising edges at 125 ns; extra clocks carry zeros
    task xfer(input [31:0] din, input [5:0] n, output [31:0] dout, output oeEnd);
        integer i;
        begin
            dout = 32'h0;
            chipSelectN = 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                sdi = (i < 32) ? din[31 - i] : 1'b0; // msb first, on fall
                #62.5 sclk = 1'b1;
                dout = {dout[30:0], sdoOe ? sdo : ~dout[0]};
                oeEnd = sdoOe;
                #62.5 sclk = 1'b0;
            end
            #62.5 chipSelectN = 1'b1;
            sdi = 1'b0;
        end
    endtask
endmodule

// file: lmfe_tb.sv
// frame engine bench: master model drives frames, answers are compared
// assumes monitor and master model compiled first
`timescale 1ns/10ps
`include "lmfe_defines.vh"
module tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg errClear = 1'b0;
    wire sclk, csN, sdi, sdo, sdoOe, regWrStb, regRdClrStb;
    wire ifErr, clkErr, crcErr, wrErr, rdErr;
    wire [6:0] regAddr;
    wire [12:0] regWrData;
    wire [23:0] tlog;
    reg [31:0] dout;
    reg oe;
    reg [23:0] explog;
    integer err_count = 0;
    integer n_compared = 0;
    // register stand-in: 7f not writable, 7e not readable
    wire [12:0] regRdData = {6'h00, regAddr} ^ 13'h1a5;
    always #5 clk = ~clk;
    lmfe_frame_engine dut_u (.clk(clk), .rst(rst), .sclk(sclk), .chipSelectN(csN),
        .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .ownIdStrap(5'h05), .generalStatusBits(7'h5a),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdClrStb(regRdClrStb), .wrAddrOk(regAddr != 7'h7f), .rdAddrOk(regAddr != 7'h7e),
        .regRdData(regRdData), .errClear(errClear), .ifErr(ifErr), .clkErr(clkErr),
        .crcErr(crcErr), .wrErr(wrErr), .rdErr(rdErr), .transactionLog(tlog));
    lmfe_spi_master m_u (.sclk(sclk), .chipSelectN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe));
    // msb-first checksum over the top n bits of m
    function [2:0] crc(input [31:0] m, input [5:0] n);
        integer i;
        begin
            crc = `LMFE_CRC_INIT;
            for (i = 31; i > 31 - n; i = i - 1)
                crc = {crc[1:0], 1'b0} ^ ((m[i] ^ crc[2]) ? `LMFE_CRC_POLY : 3'h0);
        end
    endfunction
    function [31:0] mk(input rw, input [1:0] cmd, input [4:0] id, input [6:0] a,
        input [12:0] d);
        reg [31:0] f;
        begin
            f = {rw, cmd, id, 1'b0, a, d, 3'h0};
            mk = f | crc(f, 29);
        end
    endfunction
    task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // result settles four cycles after deselect; eight leaves margin
    task frame(input [31:0] f, input [5:0] n);
        begin
            @(posedge clk);
            #1 m_u.xfer(f, n, dout, oe);
            repeat (8) @(posedge clk);
            #1;
        end
    endtask
    // clear flags, send a refused frame, check flags and answer head
    task bad(input [31:0] f, input [5:0] n, input [3:0] e);
        begin
            @(posedge clk);
            #1 errClear = 1'b1;
            @(posedge clk);
            #1 errClear = 1'b0;
            chk("clear", 32'h0, {31'h0, ifErr});
            frame(f, n);
            chk("flags", {28'h1, e}, {27'h0, ifErr, clkErr, crcErr, wrErr, rdErr});
            chk("logok", 32'h0, {31'h0, tlog[23]});
            chk("head", 32'h0, {24'h0, dout[31:24]});
        end
    endtask
    task final_report;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // hang guard
    initial begin
        #600000;
        err_count = err_count + 1;
        final_report;
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        frame(mk(1'b0, 2'h1, 5'h05, 7'h00, 13'h1fff), 6'd32);
        chk("wrans", 32'h0, dout);
        explog = {4'h8, 7'h00, 13'h1fff};
        chk("wrlog", {8'h0, explog}, {8'h0, tlog});
        frame(mk(1'b1, 2'h1, 5'h05, 7'h7f, 13'h0), 6'd32);
        chk("rdans", {8'h0, 1'b0, 7'h5a, explog[12:0],
            crc({1'b0, 7'h5a, explog[12:0], 11'h0}, 21)}, dout);
        chk("rdoe", 32'h1, {31'h0, oe});
        explog = {4'h8, 7'h7f, 13'h07f ^ 13'h1a5};
        chk("rdlog", {8'h0, explog}, {8'h0, tlog});
        frame(mk(1'b0, 2'h1, 5'h06, 7'h01, 13'h0aa), 6'd32);
        chk("idoe", 32'h0, {31'h0, oe});
        chk("idlog", {8'h0, explog}, {8'h0, tlog});
        frame(mk(1'b0, 2'h2, 5'h00, 7'h02, 13'h0555), 6'd32);
        chk("grans", {8'h0, explog}, dout);
        chk("grlog", {8'h0, 4'h8, 7'h02, 13'h0555}, {8'h0, tlog});
        bad(mk(1'b0, 2'h1, 5'h05, 7'h7f, 13'h0011), 6'd32, 4'h2);
        bad(mk(1'b0, 2'h0, 5'h05, 7'h03, 13'h0011), 6'd32, 4'h2);
        bad(mk(1'b0, 2'h3, 5'h05, 7'h03, 13'h0011), 6'd32, 4'h2);
        bad(mk(1'b1, 2'h2, 5'h05, 7'h03, 13'h0), 6'd32, 4'h1);
        bad(mk(1'b1, 2'h1, 5'h05, 7'h03, 13'h0100), 6'd32, 4'h1);
        bad(mk(1'b1, 2'h1, 5'h05, 7'h7e, 13'h0), 6'd32, 4'h1);
        bad(mk(1'b0, 2'h1, 5'h05, 7'h03, 13'h0011) ^ 32'h1, 6'd32, 4'h4);
        // last 32 bits of a long frame stay a valid codeword; last log bit is one
        bad(mk(1'b0, 2'h1, 5'h05, 7'h03, 13'h0011), 6'd33, 4'h8);
        chk("extra", 32'h2, {30'h0, dout[1:0]});
        // short frame shifts: call type reads 00 and the checksum breaks
        bad(mk(1'b0, 2'h1, 5'h05, 7'h03, 13'h0011), 6'd31, 4'he);
        frame(mk(1'b1, 2'h1, 5'h05, 7'h10, 13'h0), 6'd32);
        chk("errbit", 32'h1, {31'h0, dout[23]});
        final_report;
    end
endmodule
bind lmfe_frame_engine lmfe_fe_monitor mon_u (.clk, .rst, .chipSelectN, .sdo, .sdoOe,
    .regAddr, .regWrData, .regWrStb, .regRdClrStb, .regRdData, .errClear, .ifErr,
    .crcErr, .wrErr, .transactionLog);
